// ### hw/lwm_ctrl.sv
// Purpose: control for the per-lane element memory
// Assumes: initiate and transfer pulses are single-cycle, synchronous
// Notes:   a cycle is 10 clocks; capture at 4, output window 4..7
//
// Operation
// - memory holds 2048 words of 64 bits each.
// - word address comes from lane processor 16-bit address register.
// - destructive readout; every cycle reads then restores, 250 ns long.
// - 1024 two-word locations; unaddressed word restored unchanged.
// - write from lane or io switch; read to lane, io switch, sequencer.
// - cycle starts on initiate pulse only when memory is selected.
// - info register captures data 100 ns after initiate.
// - read/write select and data select bits pick source or target.
// - read moves word to info register, driven out during restore.
// - write gates data into info register, stored during restore.
// - outer enable covers 0-7 and 40-63, inner enable 8-39.
// - on lane writes, disabled portions keep their stored contents.
// - reads to sequencer or io switch come with a strobe.
// - sequencer and io switch data driven only 100 to 200 ns.
// - lane processor read data held until next read to lane.
// - protected write to words 0-127 skips cycle, sets error.
// - protect error stays set until sequencer clear signal.
// - transfer pulse moves lane data to sequencer, no plane cycle.
// - disabled portions load zeros during a transfer.
// - transfer timing equals memory cycle timing.
`timescale 1ns/100ps
`include "lwm_map.svh"

module lwm_ctrl #(
	parameter int WORDS  = `LWM_WORDS,
	parameter int WORD_W = `LWM_WORD_W,
	parameter int ADDR_W = `LWM_ADDR_W
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst_b,
	// sequencer control
	input  wire logic              mem_select,
	input  wire logic              initiate,
	input  wire logic              write_sel,
	input  wire logic [1:0]        data_sel,
	input  wire logic              protect,
	input  wire logic              protect_clear,
	input  wire logic              transfer,
	output logic                   protect_error,
	// lane processor
	input  wire logic [ADDR_W-1:0] address_summer,
	input  wire logic              addr_load,
	input  wire logic              outer_half_enable,
	input  wire logic              inner_half_enable,
	input  wire logic [WORD_W-1:0] lane_wdata,
	output logic      [WORD_W-1:0] lane_rdata,
	// io switch
	input  wire logic [WORD_W-1:0] iosw_wdata,
	output logic      [WORD_W-1:0] iosw_rdata,
	output logic                   iosw_strobe,
	// sequencer data
	output logic      [WORD_W-1:0] seq_rdata,
	output logic                   seq_strobe,
	// status
	output logic                   busy
);
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CYC_N = (`LWM_CYCLE_NS + `LWM_CLK_NS - 1) / `LWM_CLK_NS;
	localparam int CAP_N = (`LWM_CAPTURE_NS + `LWM_CLK_NS - 1)
		/ `LWM_CLK_NS;
	localparam int END_N = `LWM_WIN_END_NS / `LWM_CLK_NS;
	localparam int LOC_W = $clog2(WORDS) - 1;
	localparam logic [3:0] CAP_C = 4'(CAP_N - 1);
	localparam logic [3:0] END_C = 4'(END_N - 1);
	localparam logic [3:0] CYC_C = 4'(CYC_N - 1);

	initial begin
		if (WORD_W != `LWM_WORD_W || ADDR_W < LOC_W + 1 || CYC_N > 15
			|| CAP_N < 2)
			$error("unsupported lane memory parameters");
	end

	// ************************************************************
	// reset release
	// ************************************************************
	logic rst_m_q;
	logic rst_s_q;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_s_q <= rst_m_q;
		end
	end

	// ************************************************************
	// address and enables
	// ************************************************************
	logic [ADDR_W-1:0] word_address_reg_q;
	always_ff @(posedge clock or negedge rst_s_q) begin
		if (!rst_s_q)
			word_address_reg_q <= '0;
		else if (addr_load)
			word_address_reg_q <= address_summer;
	end

	wire              half_sel = word_address_reg_q[0];
	wire [LOC_W-1:0]  loc      = word_address_reg_q[LOC_W:1];
	wire              low_zone = word_address_reg_q <= `LWM_PROTECT_TOP;

	logic [WORD_W-1:0] en_mask;
	genvar gi;
	generate
		for (gi = 0; gi < WORD_W; gi++) begin : g_mask
			if (gi >= `LWM_INNER_LSB && gi <= `LWM_INNER_MSB)
				assign en_mask[gi] = inner_half_enable;
			else
				assign en_mask[gi] = outer_half_enable;
		end
	endgenerate

	// ************************************************************
	// cycle sequencing
	// ************************************************************
	lwm_pkg::lwm_state_t state_q;
	lwm_pkg::lwm_state_t state_d;
	logic [3:0]          cnt_q;
	logic                wr_q;
	logic                xfer_q;
	logic [1:0]          sel_q;
	logic [WORD_W-1:0]   mask_q;

	wire start_req = initiate & mem_select;
	wire start_xfr = transfer & ~start_req;
	wire idle      = state_q == lwm_pkg::LWM_IDLE;
	wire prot_hit  = start_req & write_sel & protect & low_zone & idle;
	wire go_mem    = idle & start_req & ~prot_hit;
	wire go_xfr    = idle & start_xfr;
	wire at_cap    = ~idle & cnt_q == CAP_C;
	wire at_end    = ~idle & cnt_q == CYC_C;
	wire in_win    = ~idle & cnt_q >= CAP_C & cnt_q <= END_C;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			lwm_pkg::LWM_IDLE: begin
				if (go_mem || go_xfr)
					state_d = lwm_pkg::LWM_ACCESS;
			end
			lwm_pkg::LWM_ACCESS: begin
				if (at_cap)
					state_d = lwm_pkg::LWM_RESTORE;
			end
			lwm_pkg::LWM_RESTORE: begin
				if (at_end)
					state_d = lwm_pkg::LWM_IDLE;
			end
		endcase
	end

	// fixed cycle length for both kinds
	always_ff @(posedge clock or negedge rst_s_q) begin
		if (!rst_s_q) begin
			state_q <= lwm_pkg::LWM_IDLE;
			cnt_q   <= 4'h0;
			wr_q    <= 1'b0;
			xfer_q  <= 1'b0;
			sel_q   <= 2'h0;
			mask_q  <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= (go_mem | go_xfr | at_end) ? 4'h0 : cnt_q + 4'h1;
			if (go_mem || go_xfr) begin
				wr_q   <= write_sel & ~go_xfr;
				xfer_q <= go_xfr;
				sel_q  <= go_xfr ? 2'(lwm_pkg::LWM_SEL_SEQ) : data_sel;
				mask_q <= en_mask;
			end
		end
	end

	// ************************************************************
	// plane and info register
	// ************************************************************
	logic [2*WORD_W-1:0] loc_rdata;
	logic [WORD_W-1:0]   memory_info_reg_q;
	logic [WORD_W-1:0]   other_q;

	// plane read one step early, so capture lands at 100 ns
	wire plane_rd = ~idle & cnt_q == CAP_C - 4'h1 & ~xfer_q;
	wire plane_wr = at_end & ~xfer_q;

	// 2048 words as 1024 two-word locations
	lwm_plane #(
		.LOCS   (WORDS / 2),
		.WORD_W (WORD_W)
	) u_plane (
		.clock   (clock),
		.rst_n_s (rst_s_q),
		.loc     (loc),
		.rd      (plane_rd),
		.wr      (plane_wr),
		.wdata   (half_sel ? {memory_info_reg_q, other_q}
			: {other_q, memory_info_reg_q}),
		.rdata   (loc_rdata)
	);

	wire [WORD_W-1:0] plane_word  = half_sel ? loc_rdata[2*WORD_W-1:WORD_W]
		: loc_rdata[WORD_W-1:0];
	wire [WORD_W-1:0] plane_other = half_sel ? loc_rdata[WORD_W-1:0]
		: loc_rdata[2*WORD_W-1:WORD_W];
	wire [WORD_W-1:0] ext_wdata = sel_q == 2'(lwm_pkg::LWM_SEL_IOSW)
		? iosw_wdata : lane_wdata;
	wire lane_src = sel_q == 2'(lwm_pkg::LWM_SEL_LANE);
	// lane write merges with stored data
	wire [WORD_W-1:0] wr_merge = lane_src
		? (ext_wdata & mask_q) | (plane_word & ~mask_q) : ext_wdata;
	wire [WORD_W-1:0] xfr_word = lane_wdata & mask_q;
	// capture one step after plane read
	wire cap_mir = at_cap;
	wire [WORD_W-1:0] mir_d = xfer_q ? xfr_word
		: (wr_q ? wr_merge : plane_word);

	always_ff @(posedge clock or negedge rst_s_q) begin
		if (!rst_s_q) begin
			memory_info_reg_q <= '0;
			other_q           <= '0;
		end else if (cap_mir) begin
			memory_info_reg_q <= mir_d;
			other_q           <= plane_other;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	logic [WORD_W-1:0] lane_rdata_q;
	logic              err_q;
	wire rd_cyc = ~wr_q | xfer_q;
	wire win_ok = in_win & cnt_q > CAP_C & rd_cyc;
	wire seq_win  = win_ok & sel_q == 2'(lwm_pkg::LWM_SEL_SEQ);
	wire iosw_win = win_ok & sel_q == 2'(lwm_pkg::LWM_SEL_IOSW) & ~xfer_q;

	always_ff @(posedge clock or negedge rst_s_q) begin
		if (!rst_s_q) begin
			lane_rdata_q <= '0;
			err_q        <= 1'b0;
		end else begin
			// lane data held until next read to lane
			if (at_end && !wr_q && !xfer_q && lane_src)
				lane_rdata_q <= memory_info_reg_q;
			if (prot_hit)
				err_q <= 1'b1;
			else if (protect_clear)
				err_q <= 1'b0;
		end
	end

	assign lane_rdata    = lane_rdata_q;
	assign seq_rdata     = seq_win ? memory_info_reg_q : '0;
	assign iosw_rdata    = iosw_win ? memory_info_reg_q : '0;
	assign seq_strobe    = seq_win;
	assign iosw_strobe   = iosw_win;
	assign protect_error = err_q;
	assign busy          = ~idle;

	// ************************************************************
	// checks
	// ************************************************************
	chk_protect_sets: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		prot_hit |=> protect_error)
		else $error("protect error not set");
	chk_protect_holds: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		protect_error & ~protect_clear |=> protect_error)
		else $error("protect error dropped without clear");
	chk_protect_nocyc: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		prot_hit |=> state_q == lwm_pkg::LWM_IDLE)
		else $error("protected write started a cycle");
	chk_strobe_window: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		(seq_strobe | iosw_strobe) |-> cnt_q > CAP_C && cnt_q <= END_C)
		else $error("strobe outside window");
	chk_window_data: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		(seq_strobe | iosw_strobe) |=> $stable(memory_info_reg_q))
		else $error("info register changed in output window");
	chk_read_strobe: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		go_mem & ~write_sel & (data_sel == 2'(lwm_pkg::LWM_SEL_SEQ)
		| data_sel == 2'(lwm_pkg::LWM_SEL_IOSW))
		|-> ##5 (seq_strobe | iosw_strobe) [*4]
		##1 ~(seq_strobe | iosw_strobe))
		else $error("read window wrong");
	chk_cycle_length: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		(go_mem | go_xfr) |=> busy [*8] ##1 busy ##1 busy ##1 ~busy)
		else $error("cycle length wrong");
	chk_unselected_idle: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		idle & ~mem_select & ~transfer |=> ~busy)
		else $error("cycle without select");
	chk_xfer_no_plane: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		xfer_q |-> ~plane_rd & ~plane_wr)
		else $error("transfer touched plane");
	chk_lane_hold: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		idle |=> $stable(lane_rdata))
		else $error("lane data changed while idle");
	chk_xfer_strobe: assert property (@(posedge clock)
		disable iff (!rst_s_q)
		go_xfr |-> ##5 seq_strobe [*4] ##1 ~seq_strobe)
		else $error("transfer window wrong");
endmodule // lwm_ctrl

// ### hw/lwm_plane.sv
// Purpose: destructive readout plane, 1024 locations of two words
// Assumes: read and restore strobes come from the controller
// Notes:   each access moves the whole 128-bit location
`timescale 1ns/100ps
`include "lwm_map.svh"

module lwm_plane #(
	parameter int LOCS   = `LWM_LOCS,
	parameter int WORD_W = `LWM_WORD_W
) (
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst_n_s,
	// access
	input  wire logic [$clog2(LOCS)-1:0] loc,
	input  wire logic                    rd,
	input  wire logic                    wr,
	input  wire logic [2*WORD_W-1:0]     wdata,
	output logic      [2*WORD_W-1:0]     rdata
);
	logic [2*WORD_W-1:0] mem [LOCS];

	initial begin
		if (LOCS < 2)
			$error("plane needs at least two locations");
	end

	// read then restore the whole location
	always_ff @(posedge clock) begin
		if (wr)
			mem[loc] <= wdata;
	end

	always_ff @(posedge clock or negedge rst_n_s) begin
		if (!rst_n_s)
			rdata <= '0;
		else if (rd)
			rdata <= mem[loc];
	end
endmodule // lwm_plane

// ### inc/lwm_map.svh
// Purpose: constants for the lane word memory control
// Assumes: 40 MHz clock, times in nanoseconds
// Notes:   counts derived from times in the module
`ifndef LWM_MAP_SVH
`define LWM_MAP_SVH

`define LWM_WORDS         2048
`define LWM_WORD_W        64
`define LWM_ADDR_W        16
`define LWM_LOCS          1024
`define LWM_CLK_NS        25
`define LWM_CYCLE_NS      250
`define LWM_CAPTURE_NS    100
`define LWM_WIN_END_NS    200
`define LWM_PROTECT_TOP   16'h007f
`define LWM_OUTER_LO_MSB  7
`define LWM_INNER_LSB     8
`define LWM_INNER_MSB     39
`define LWM_OUTER_HI_LSB  40

`endif

// ### inc/lwm_pkg.sv
// Purpose: types for the lane word memory control
// Assumes: nothing
// Notes:   data select codes
package lwm_pkg;
	// write source / read destination select
	typedef enum logic [1:0] {
		LWM_SEL_LANE = 2'h0,
		LWM_SEL_IOSW = 2'h1,
		LWM_SEL_SEQ  = 2'h2
	} lwm_sel_t;

	typedef enum logic [1:0] {
		LWM_IDLE,
		LWM_ACCESS,
		LWM_RESTORE
	} lwm_state_t;
endpackage

// ### tb/lane_word_memory_control_tb_top.sv
// Purpose: self-checking bench for the lane memory control
// Assumes: sequencer model issues cycles, bench drives lane side
// Notes:   io write data is the inverse of lane write data
`timescale 1ns/100ps

module lane_word_memory_control_tb_top;
	logic        clock;
	logic        rst_b;
	logic        addr_load;
	logic        oe;
	logic        ie;
	logic [15:0] addr;
	logic [63:0] lw;
	logic [63:0] iw;
	logic        mem_select, initiate, write_sel, protect;
	logic        protect_clear, transfer, protect_error, busy;
	logic        iosw_strobe, seq_strobe;
	logic [1:0]  data_sel;
	logic [63:0] lane_rdata, iosw_rdata, seq_rdata;
	int          errors;
	int          compares;
	int          n;
	localparam logic [63:0] A = 64'h0123456789abcdef;
	localparam logic [63:0] B = 64'hfedcba9876543210;
	localparam logic [63:0] C = 64'h5a5a5a5a0f0f0f0f;

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	lwm_ctrl dut (.clock(clock), .rst_b(rst_b), .mem_select(mem_select),
		.initiate(initiate), .write_sel(write_sel), .data_sel(data_sel),
		.protect(protect), .protect_clear(protect_clear),
		.transfer(transfer), .protect_error(protect_error),
		.address_summer(addr), .addr_load(addr_load),
		.outer_half_enable(oe), .inner_half_enable(ie),
		.lane_wdata(lw), .lane_rdata(lane_rdata), .iosw_wdata(iw),
		.iosw_rdata(iosw_rdata), .iosw_strobe(iosw_strobe),
		.seq_rdata(seq_rdata), .seq_strobe(seq_strobe), .busy(busy));

	lwm_seq_model seq (.clock(clock), .mem_select(mem_select),
		.initiate(initiate), .write_sel(write_sel), .data_sel(data_sel),
		.protect(protect), .protect_clear(protect_clear),
		.transfer(transfer), .protect_error(protect_error), .busy(busy),
		.seq_rdata(seq_rdata), .seq_strobe(seq_strobe),
		.iosw_rdata(iosw_rdata), .iosw_strobe(iosw_strobe));

	// ****************************************
	// compare and drive
	// ****************************************
	task automatic cmp_word(input string what, input logic [63:0] exp,
	                        input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_int(input string what, input int exp, input int got);
		compares++;
		if (got != exp) begin
			errors++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// outer 0-7 and 40-63, inner 8-39
	function automatic logic [63:0] mask(input logic o, input logic i);
		return {{24{o}}, {32{i}}, {8{o}}};
	endfunction

	task automatic op(input logic [15:0] a, input logic o, input logic i,
		input logic [63:0] d, input logic wr, input logic [1:0] sel,
		input logic xf);
		@(posedge clock);
		addr <= a;
		addr_load <= 1'b1;
		oe <= o;
		ie <= i;
		lw <= d;
		iw <= ~d;
		@(posedge clock);
		addr_load <= 1'b0;
		seq.issue(wr, sel, xf, n);
	endtask

	task automatic strobed(input logic [63:0] exp);
		cmp_int("cycle length", 10, n);
		cmp_word("strobed data", exp, seq.got);
		cmp_int("strobe window", 1, int'(seq.first >= 5 && seq.last <= 8));
	endtask

	task automatic rd(input logic [15:0] a, input logic [1:0] sel,
	                  input logic [63:0] exp);
		op(a, 1'b1, 1'b1, 64'h0, 1'b0, sel, 1'b0);
		if (sel == 2'h0) begin
			cmp_int("cycle length", 10, n);
			cmp_word("lane read", exp, lane_rdata);
		end else
			strobed(exp);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_paths();
		op(16'h0200, 1'b1, 1'b1, A, 1'b1, 2'h0, 1'b0);
		cmp_int("write length", 10, n);
		op(16'h0201, 1'b0, 1'b0, ~B, 1'b1, 2'h1, 1'b0);
		rd(16'h0200, 2'h2, A);
		rd(16'h0201, 2'h1, B);
		rd(16'h0a00, 2'h0, A);
	endtask

	task automatic t_masks();
		for (int k = 0; k < 4; k++) begin
			op(16'h0300, 1'b1, 1'b1, '1, 1'b1, 2'h0, 1'b0);
			op(16'h0300, k[1], k[0], 64'h0, 1'b1, 2'h0, 1'b0);
			rd(16'h0300, 2'h0, ~mask(k[1], k[0]));
		end
		op(16'h0310, 1'b1, 1'b1, C, 1'b1, 2'h0, 1'b0);
		cmp_word("lane hold", 64'h0, lane_rdata);
	endtask

	task automatic t_protect();
		op(16'h007f, 1'b1, 1'b1, A, 1'b1, 2'h0, 1'b0);
		seq.set_ctl(1'b1, 1'b1);
		op(16'h007f, 1'b1, 1'b1, C, 1'b1, 2'h0, 1'b0);
		cmp_int("protected cycle", 1, n);
		cmp_word("error set", 64'h1, {63'h0, protect_error});
		rd(16'h007f, 2'h2, A);
		op(16'h0080, 1'b1, 1'b1, C, 1'b1, 2'h0, 1'b0);
		cmp_int("free word", 10, n);
		cmp_word("error held", 64'h1, {63'h0, protect_error});
		seq.clear();
		cmp_word("error cleared", 64'h0, {63'h0, protect_error});
		seq.set_ctl(1'b1, 1'b0);
	endtask

	task automatic t_xfer();
		for (int k = 0; k < 4; k++) begin
			op(16'h0200, k[1], k[0], C, 1'b0, 2'h2, 1'b1);
			strobed(C & mask(k[1], k[0]));
		end
		rd(16'h0200, 2'h0, A);
	endtask

	task automatic t_unsel();
		seq.set_ctl(1'b0, 1'b0);
		op(16'h0200, 1'b1, 1'b1, C, 1'b1, 2'h0, 1'b0);
		cmp_int("unselected", 1, n);
		seq.set_ctl(1'b1, 1'b0);
		rd(16'h0200, 2'h0, A);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#(4000 * 25);
		errors++;
		$display("[FAIL] watchdog expired");
		summarize();
	end

	initial begin
		errors = 0;
		compares = 0;
		rst_b = 1'b0;
		addr_load = 1'b0;
		oe = 1'b0;
		ie = 1'b0;
		addr = 16'h0;
		lw = 64'h0;
		iw = 64'h0;
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		repeat (5) @(posedge clock);
		t_paths();
		t_masks();
		t_protect();
		t_xfer();
		t_unsel();
		cmp_int("idle data", 0, seq.bad);
		summarize();
	end
endmodule // lane_word_memory_control_tb_top

// ### tb/lwm_seq_model.sv
// Purpose: sequencer unit and io switch stand-in for the lane memory
// Assumes: one request at a time, launched just after a rising edge
// Notes:   records strobe timing and strobed data of each cycle
`timescale 1ns/100ps

module lwm_seq_model (
	// clock
	input  wire logic        clock,
	// sequencer control
	output logic             mem_select,
	output logic             initiate,
	output logic             write_sel,
	output logic [1:0]       data_sel,
	output logic             protect,
	output logic             protect_clear,
	output logic             transfer,
	// memory answers
	input  wire logic        protect_error,
	input  wire logic        busy,
	input  wire logic [63:0] seq_rdata,
	input  wire logic        seq_strobe,
	input  wire logic [63:0] iosw_rdata,
	input  wire logic        iosw_strobe
);
	int          cnt;
	int          first;
	int          last;
	int          bad;
	logic [63:0] got;

	initial begin
		mem_select = 1'b1;
		initiate = 1'b0;
		write_sel = 1'b0;
		data_sel = 2'h0;
		protect = 1'b0;
		protect_clear = 1'b0;
		transfer = 1'b0;
		cnt = 0;
		first = 0;
		last = 0;
		bad = 0;
	end

	// ****************************************
	// strobe watch
	// ****************************************
	// edges since take, idle data
	always @(posedge clock) begin
		cnt <= (initiate | transfer) ? 1 : cnt + 1;
		if (seq_strobe | iosw_strobe) begin
			got <= seq_strobe ? seq_rdata : iosw_rdata;
			if (first == 0)
				first <= cnt;
			last <= cnt;
		end
		if ((!seq_strobe && seq_rdata !== 64'h0) ||
		    (!iosw_strobe && iosw_rdata !== 64'h0))
			bad <= bad + 1;
	end

	task automatic set_ctl(input logic s, input logic p);
		@(posedge clock);
		mem_select <= s;
		protect <= p;
	endtask

	task automatic clear();
		@(posedge clock);
		protect_clear <= 1'b1;
		@(posedge clock);
		protect_clear <= 1'b0;
		@(posedge clock);
		#1;
	endtask

	// one pulse, wait for busy to fall
	task automatic issue(input logic wr, input logic [1:0] sel,
	                     input logic xf, output int n);
		first = 0;
		n = 0;
		@(posedge clock);
		initiate <= !xf;
		transfer <= xf;
		write_sel <= wr;
		data_sel <= sel;
		@(posedge clock);
		initiate <= 1'b0;
		transfer <= 1'b0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (busy === 1'b1 && n < 40);
	endtask
endmodule // lwm_seq_model
